// ===== common/sre_map.svh
// sre_map.svh: positions, encodings, reset values and timing counts of the eeprom core
// assumes inclusion by bare name; holds definitions only
`ifndef SRE_MAP_SVH
`define SRE_MAP_SVH
`define SRE_ARRAY_AW           15
`define SRE_RX_AW              16
`define SRE_PAGE_AW            6
`define SRE_OP_READ            8'h03
`define SRE_OP_WRITE           8'h02
`define SRE_ERASED             8'hff
`define SRE_NV_DELIVERY        3'h0
`define SRE_NV_SWD_POS         2
`define SRE_NV_BPH_POS         1
`define SRE_NV_BPL_POS         0
`define SRE_SYNC_RST           3'h0
`define SRE_CLK_PERIOD_NS      4
`define SRE_WRITE_CYCLE_TIME_NS 5000000
`define SRE_WC_CYCLES (`SRE_WRITE_CYCLE_TIME_NS / `SRE_CLK_PERIOD_NS)
`endif

// ===== common/sre_pkg.sv
// sre_pkg: types shared by the eeprom core and its array
// assumes sre_map.svh on the include path
package sre_pkg;
   typedef enum logic [2:0] {
      ST_DESEL  = 3'h0,
      ST_OPCODE = 3'h1,
      ST_ADDR   = 3'h2,
      ST_RDATA  = 3'h3,
      ST_WDATA  = 3'h4,
      ST_IGNORE = 3'h5
   } sre_state_t;
   typedef logic [7:0] sre_byte_t;
   typedef logic [2:0] sre_nv_t;
endpackage

// ===== common/sre_mem_if.sv
// sre_mem_if: array port between serial control and nonvolatile store
// assumes one clock shared by both ends
`timescale 1ns/10ps
interface sre_mem_if #(parameter int AW = 15);
   logic [AW-1:0]     rd_addr;
   sre_pkg::sre_byte_t rd_data;
   logic              wr_en;
   logic [AW-1:0]     wr_addr;
   sre_pkg::sre_byte_t wr_data;
   logic              sr_load;
   sre_pkg::sre_nv_t  sr_data;
   sre_pkg::sre_nv_t  nv_bits;
   modport ctl (output rd_addr, wr_en, wr_addr, wr_data, sr_load, sr_data,
                input rd_data, nv_bits);
   modport mem (input rd_addr, wr_en, wr_addr, wr_data, sr_load, sr_data,
                output rd_data, nv_bits);
endinterface

// ===== hw/sre_nvm.sv
// sre_nvm: byte array and nonvolatile status bits
// assumes a single clock; contents survive RESETN like real cells
`timescale 1ns/10ps
`include "sre_map.svh"
module sre_nvm #(
   parameter int AW = `SRE_ARRAY_AW
) (
   // clock
   input wire logic clk,
   // array port
   sre_mem_if.mem   mif
);
   import sre_pkg::*;

   // cells start in delivery state; written by the clocked port only
   logic [7:0] mem_ff [0:(1<<AW)-1] = '{default: `SRE_ERASED};
   sre_byte_t  rd_ff;
   sre_nv_t    nv_ff = `SRE_NV_DELIVERY;

   if (AW < 1 || AW > 20) begin : g_bad_aw
      $error("sre_nvm: array address width unusable");
   end

   //==========================================================
   // array
   always_ff @(posedge clk) begin
      if (mif.wr_en) begin
         mem_ff[mif.wr_addr] <= mif.wr_data;
      end
   end

   always_ff @(posedge clk) begin
      rd_ff <= mem_ff[mif.rd_addr];
   end

   //==========================================================
   // status bits: no reset, they outlive a power cycle
   always_ff @(posedge clk) begin
      if (mif.sr_load) begin
         nv_ff <= mif.sr_data;
      end
   end

   assign mif.rd_data = rd_ff;
   assign mif.nv_bits = nv_ff;
endmodule

// ===== hw/sre_top.sv
// sre_top: serial command logic for array read and byte/page write
// assumes the spi pins are asynchronous and the status logic sits outside
`timescale 1ns/10ps
`include "sre_map.svh"

// Summary of operation
// - read: select low, opcode, address, then addressed byte shifts out
// - top address bit is ignored when picking the array location
// - read keeps streaming next byte while select stays low
// - read pointer wraps from top address to zero
// - select rise ends a read anywhere; any start address accepted
// - read opcode refused while a write cycle runs
// - select rise at byte boundary starts timed write; busy clears after
// - more data bytes in one selection go in one write cycle
// - write pointer steps low six bits only, wraps in 64-byte page
// - write refused unless write enable latch is set
// - write refused while an earlier write cycle runs
// - write dropped unless select rises right after a whole data byte
// - write refused when the page lies in the protected area
// - after reset wait for a select falling edge before any command
// - no paused hold condition after reset
// - reset clears write enable latch and write in progress
// - status disable and protect bits keep value across resets
// - delivered array reads all ones, status bits zero
// - write in progress is one during the cycle, zero after
// - either protect bit set marks its array area protected
module sre_top #(
   parameter int        AW        = `SRE_ARRAY_AW,
   parameter int        PAGE_AW   = `SRE_PAGE_AW,
   parameter logic [7:0] OP_READ  = `SRE_OP_READ,
   parameter logic [7:0] OP_WRITE = `SRE_OP_WRITE,
   parameter int        WC_CYCLES = `SRE_WC_CYCLES
) (
   // system
   input  wire logic           CLOCK,
   input  wire logic           RESETN,
   // serial pins
   input  wire logic           CHIP_SEL_N,
   input  wire logic           SCLK,
   input  wire logic           SDI,
   output logic                SDO,
   output logic                SDO_OE,
   // status logic side
   input  wire logic           WRITE_ENABLE_SET,
   input  wire logic           WRITE_ENABLE_CLR,
   input  wire logic           STATUS_LOAD,
   input  wire sre_pkg::sre_nv_t STATUS_DATA,
   // status view
   output logic                WRITE_ENABLE_LATCH,
   output logic                WRITE_IN_PROGRESS,
   output logic                STATUS_WRITE_DISABLE,
   output logic                BLOCK_PROTECT_HI,
   output logic                BLOCK_PROTECT_LO
);
   import sre_pkg::*;

   localparam int PAGE = 1 << PAGE_AW;
   localparam int TW   = $clog2(WC_CYCLES + 1);
   // select syncs to low so a select held through reset makes no edge
   localparam logic [2:0] SYNC_RST = `SRE_SYNC_RST;

   //==========================================================
   // elaboration checks
   if (AW <= PAGE_AW || PAGE_AW < 1 || AW >= `SRE_RX_AW) begin : g_bad_geom
      $error("sre_top: array and page widths unusable");
   end
   if (WC_CYCLES < 1) begin : g_bad_time
      $error("sre_top: write cycle count below one");
   end

   //==========================================================
   // declarations
   logic [2:0]         sync1_ff;
   logic [2:0]         sync2_ff;
   logic [2:0]         pins;
   logic               cs_n;
   logic               sclk_s;
   logic               sdi_s;
   logic               cs_prev_ff;
   logic               sclk_prev_ff;
   logic               cs_fall;
   logic               cs_rise;
   logic               sclk_rise;
   logic               sclk_fall;
   sre_state_t         state_ff;
   logic [2:0]         bitcnt_ff;
   logic               abyte_ff;
   logic [7:0]         shreg_ff;
   logic [15:0]        addr_ff;
   logic               is_write_ff;
   logic               got_byte_ff;
   logic [AW-1:0]      rd_addr_ff;
   logic [2:0]         txcnt_ff;
   logic               sdo_ff;
   logic               sdo_oe_ff;
   logic [AW-1:0]      pg_base_ff;
   logic [PAGE_AW-1:0] pg_ptr_ff;
   sre_byte_t          pg_data_ff [0:PAGE-1];
   logic [PAGE-1:0]    pg_mask_ff;
   logic               wip_ff;
   logic               wel_ff;
   logic [TW-1:0]      timer_ff;
   logic [PAGE_AW:0]   cmt_ff;
   logic               wr_en_ff;
   logic [AW-1:0]      wr_addr_ff;
   sre_byte_t          wr_data_ff;
   logic               start_wr;
   logic               end_wr;
   logic [7:0]         rx_byte;
   logic [15:0]        rx_addr;
   sre_nv_t            nv;

   sre_mem_if #(.AW(AW)) mif ();

   //==========================================================
   // protected area lookup
   function automatic logic blk_protected(input logic [1:0] bp,
                                          input logic [AW-1:0] a);
      logic hit;
      hit = 1'b0;
      unique case (bp)
         2'h0: hit = 1'b0;
         2'h1: hit = (a[AW-1:AW-2] == 2'h3);
         2'h2: hit = a[AW-1];
         2'h3: hit = 1'b1;
      endcase
      return hit;
   endfunction

   //==========================================================
   // pin synchronisers, only the second stage is read
   assign pins = {SDI, SCLK, CHIP_SEL_N};

   for (genvar i = 0; i < 3; i++) begin : g_sync
      always_ff @(posedge CLOCK) begin
         if (!RESETN) begin
            sync1_ff[i] <= SYNC_RST[i];
            sync2_ff[i] <= SYNC_RST[i];
         end else begin
            sync1_ff[i] <= pins[i];
            sync2_ff[i] <= sync1_ff[i];
         end
      end
   end

   assign cs_n   = sync2_ff[0];
   assign sclk_s = sync2_ff[1];
   assign sdi_s  = sync2_ff[2];

   // select held low through reset gives no falling edge
   always_ff @(posedge CLOCK) begin
      if (!RESETN) begin
         cs_prev_ff   <= 1'b0;
         sclk_prev_ff <= 1'b0;
      end else begin
         cs_prev_ff   <= cs_n;
         sclk_prev_ff <= sclk_s;
      end
   end

   assign cs_fall   = cs_prev_ff & ~cs_n;
   assign cs_rise   = ~cs_prev_ff & cs_n;
   assign sclk_rise = ~cs_n & sclk_s & ~sclk_prev_ff;
   assign sclk_fall = ~cs_n & ~sclk_s & sclk_prev_ff;

   assign rx_byte = {shreg_ff[6:0], sdi_s};
   assign rx_addr = {addr_ff[14:0], sdi_s};
   assign nv      = mif.nv_bits;

   // write committed only on a clean byte boundary
   assign start_wr = cs_rise && state_ff == ST_WDATA && bitcnt_ff == 3'h0
                     && got_byte_ff;
   assign end_wr   = wip_ff && timer_ff == '0;

   //==========================================================
   // command sequencer; no hold state exists, so none after reset
   always_ff @(posedge CLOCK) begin
      if (!RESETN) begin
         state_ff    <= ST_DESEL;
         bitcnt_ff   <= 3'h0;
         abyte_ff    <= 1'b0;
         shreg_ff    <= 8'h00;
         addr_ff     <= 16'h0000;
         is_write_ff <= 1'b0;
      end else if (cs_n) begin
         state_ff  <= ST_DESEL;
         bitcnt_ff <= 3'h0;
      end else if (cs_fall) begin
         state_ff  <= ST_OPCODE;
         bitcnt_ff <= 3'h0;
         abyte_ff  <= 1'b0;
      end else if (sclk_rise) begin
         bitcnt_ff <= bitcnt_ff + 3'h1;
         shreg_ff  <= rx_byte;
         unique case (state_ff)
            ST_OPCODE: begin
               if (bitcnt_ff == 3'h7) begin
                  if (rx_byte == OP_READ && !wip_ff) begin
                     state_ff    <= ST_ADDR;
                     is_write_ff <= 1'b0;
                  end else if (rx_byte == OP_WRITE && wel_ff && !wip_ff) begin
                     state_ff    <= ST_ADDR;
                     is_write_ff <= 1'b1;
                  end else begin
                     state_ff <= ST_IGNORE;
                  end
               end
            end
            ST_ADDR: begin
               addr_ff <= rx_addr;
               if (bitcnt_ff == 3'h7) begin
                  abyte_ff <= 1'b1;
                  if (abyte_ff) begin
                     if (!is_write_ff) begin
                        state_ff <= ST_RDATA;
                     end else if (blk_protected({nv[`SRE_NV_BPH_POS],
                                                 nv[`SRE_NV_BPL_POS]},
                                                rx_addr[AW-1:0])) begin
                        state_ff <= ST_IGNORE;
                     end else begin
                        state_ff <= ST_WDATA;
                     end
                  end
               end
            end
            ST_RDATA, ST_WDATA, ST_IGNORE, ST_DESEL: begin
               state_ff <= state_ff;
            end
         endcase
      end
   end

   //==========================================================
   // page buffer collects write data
   always_ff @(posedge CLOCK) begin
      if (!RESETN) begin
         pg_base_ff  <= '0;
         pg_ptr_ff   <= '0;
         pg_mask_ff  <= '0;
         got_byte_ff <= 1'b0;
      end else if (cs_fall) begin
         got_byte_ff <= 1'b0;
      end else if (sclk_rise && state_ff == ST_ADDR && abyte_ff && bitcnt_ff == 3'h7) begin
         // cleared only once a command is accepted, never under a running commit
         pg_mask_ff <= '0;
         pg_base_ff <= rx_addr[AW-1:0];
         pg_ptr_ff  <= rx_addr[PAGE_AW-1:0];
      end else if (sclk_rise && state_ff == ST_WDATA && bitcnt_ff == 3'h7) begin
         pg_mask_ff[pg_ptr_ff] <= 1'b1;
         pg_ptr_ff             <= pg_ptr_ff + 1'b1;
         got_byte_ff           <= 1'b1;
      end
   end

   // data array has no reset; mask alone says what is valid
   always_ff @(posedge CLOCK) begin
      if (sclk_rise && state_ff == ST_WDATA && bitcnt_ff == 3'h7) begin
         pg_data_ff[pg_ptr_ff] <= rx_byte;
      end
   end

   //==========================================================
   // read pointer and serial output
   always_ff @(posedge CLOCK) begin
      if (!RESETN) begin
         rd_addr_ff <= '0;
      end else if (sclk_rise && state_ff == ST_ADDR && abyte_ff && bitcnt_ff == 3'h7) begin
         rd_addr_ff <= rx_addr[AW-1:0];
      end else if (sclk_fall && state_ff == ST_RDATA && txcnt_ff == 3'h7) begin
         rd_addr_ff <= rd_addr_ff + 1'b1;
      end
   end

   // array answers a cycle after the pointer moves, long before a fall
   always_ff @(posedge CLOCK) begin
      if (!RESETN) begin
         txcnt_ff  <= 3'h0;
         sdo_ff    <= 1'b0;
         sdo_oe_ff <= 1'b0;
      end else if (cs_n || state_ff != ST_RDATA) begin
         txcnt_ff  <= 3'h0;
         sdo_oe_ff <= 1'b0;
      end else if (sclk_fall) begin
         sdo_ff    <= mif.rd_data[3'h7 - txcnt_ff];
         sdo_oe_ff <= 1'b1;
         txcnt_ff  <= txcnt_ff + 3'h1;
      end
   end

   //==========================================================
   // self-timed write cycle and its commit of the page
   always_ff @(posedge CLOCK) begin
      if (!RESETN) begin
         wip_ff   <= 1'b0;
         timer_ff <= '0;
         cmt_ff   <= '0;
      end else if (start_wr) begin
         wip_ff   <= 1'b1;
         timer_ff <= TW'(WC_CYCLES - 1);
         cmt_ff   <= '0;
      end else if (wip_ff) begin
         timer_ff <= timer_ff - 1'b1;
         if (!cmt_ff[PAGE_AW]) begin
            cmt_ff <= cmt_ff + 1'b1;
         end
         if (end_wr) begin
            wip_ff <= 1'b0;
         end
      end
   end

   // one page slot per clock; only received slots are programmed
   always_ff @(posedge CLOCK) begin
      if (!RESETN) begin
         wr_en_ff   <= 1'b0;
         wr_addr_ff <= '0;
         wr_data_ff <= 8'h00;
      end else begin
         wr_en_ff   <= wip_ff && !cmt_ff[PAGE_AW] && pg_mask_ff[cmt_ff[PAGE_AW-1:0]];
         wr_addr_ff <= {pg_base_ff[AW-1:PAGE_AW], cmt_ff[PAGE_AW-1:0]};
         wr_data_ff <= pg_data_ff[cmt_ff[PAGE_AW-1:0]];
      end
   end

   //==========================================================
   // write enable latch: a set beats a same-cycle clear
   always_ff @(posedge CLOCK) begin
      if (!RESETN) begin
         wel_ff <= 1'b0;
      end else if (WRITE_ENABLE_SET) begin
         wel_ff <= 1'b1;
      end else if (WRITE_ENABLE_CLR || end_wr) begin
         wel_ff <= 1'b0;
      end
   end

   //==========================================================
   // array and status store
   assign mif.rd_addr = rd_addr_ff;
   assign mif.wr_en   = wr_en_ff;
   assign mif.wr_addr = wr_addr_ff;
   assign mif.wr_data = wr_data_ff;
   assign mif.sr_load = STATUS_LOAD;
   assign mif.sr_data = STATUS_DATA;

   sre_nvm #(
      .AW (AW)
   ) u_nvm (
      .clk (CLOCK),
      .mif (mif)
   );

   //==========================================================
   // outputs
   assign SDO                  = sdo_ff;
   assign SDO_OE               = sdo_oe_ff;
   assign WRITE_ENABLE_LATCH   = wel_ff;
   assign WRITE_IN_PROGRESS    = wip_ff;
   assign STATUS_WRITE_DISABLE = nv[`SRE_NV_SWD_POS];
   assign BLOCK_PROTECT_HI     = nv[`SRE_NV_BPH_POS];
   assign BLOCK_PROTECT_LO     = nv[`SRE_NV_BPL_POS];
endmodule

// ===== tb/sre_spi_master.sv
// sre_spi_master: spi mode 0 bus host driving the eeprom pins
// assumes the bench clock paces it; 20 clocks per half period
`timescale 1ns/10ps
module sre_spi_master (
   // pacing clock
   input  wire logic clk,
   // spi pins
   output logic      cs_n,
   output logic      sck,
   output logic      mosi,
   input  wire logic miso
);
   // ========
   // idle state
   initial begin
      cs_n = 1'b1;
      sck  = 1'b0;
      mosi = 1'b0;
   end
   // ========
   // bus tasks
   task automatic sel();
      @(negedge clk);
      cs_n = 1'b0;
      repeat (4) @(negedge clk);
   endtask
   task automatic desel();
      @(negedge clk);
      cs_n = 1'b1;
      // unkind: data line flips once released
      mosi = ~mosi;
      repeat (12) @(negedge clk);
   endtask
   // data set while clock low, taken at rise
   task automatic bit1(input logic b, output logic q);
      mosi = b;
      repeat (20) @(negedge clk);
      sck = 1'b1;
      q   = miso;
      repeat (20) @(negedge clk);
      sck = 1'b0;
   endtask
   task automatic xb(input logic [7:0] t, output logic [7:0] q);
      for (int i = 7; i >= 0; i--) begin
         bit1(t[i], q[i]);
      end
   endtask
endmodule

// ===== tb/sre_top_assertions.sv
// sre_top_assertions: port checks of the eeprom command core
// assumes binding onto sre_top; sees its ports only
`timescale 1ns/10ps
module sre_top_assertions #(
   parameter int WC_CYCLES = 200
) (
   // system
   input wire logic CLOCK,
   input wire logic RESETN,
   // serial pins
   input wire logic CHIP_SEL_N,
   input wire logic SCLK,
   input wire logic SDO,
   input wire logic SDO_OE,
   // status
   input wire logic WRITE_ENABLE_SET,
   input wire logic WRITE_ENABLE_CLR,
   input wire logic STATUS_LOAD,
   input wire logic WRITE_ENABLE_LATCH,
   input wire logic WRITE_IN_PROGRESS,
   input wire logic STATUS_WRITE_DISABLE,
   input wire logic BLOCK_PROTECT_HI,
   input wire logic BLOCK_PROTECT_LO
);
   // ========
   // helper
   int         busy_ff;
   logic [2:0] nv;
   assign nv = {STATUS_WRITE_DISABLE, BLOCK_PROTECT_HI, BLOCK_PROTECT_LO};
   always_ff @(posedge CLOCK) begin
      if (!RESETN || !WRITE_IN_PROGRESS) begin
         busy_ff <= 0;
      end else begin
         busy_ff <= busy_ff + 1;
      end
   end
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RESETN);
   // ========
   // assertions
   reset_state_a: assert property ($rose(RESETN) |->
      !WRITE_ENABLE_LATCH && !WRITE_IN_PROGRESS && !SDO_OE) else $error("state after reset");
   oe_desel_a: assert property (CHIP_SEL_N [*5] |-> !SDO_OE)
      else $error("sdo driven while deselected");
   oe_busy_a: assert property ($rose(SDO_OE) |-> !WRITE_IN_PROGRESS)
      else $error("read taken during write cycle");
   oe_edge_a: assert property ($rose(SDO_OE) |-> !CHIP_SEL_N && !SCLK)
      else $error("sdo drive not after clock fall");
   sdo_fall_a: assert property (SDO_OE && $past(SDO_OE) && $changed(SDO) |-> !SCLK)
      else $error("sdo changed with clock high");
   wel_set_a: assert property (WRITE_ENABLE_SET && !WRITE_IN_PROGRESS |=>
      WRITE_ENABLE_LATCH) else $error("latch not set");
   wel_clr_a: assert property (WRITE_ENABLE_CLR && !WRITE_ENABLE_SET |=>
      !WRITE_ENABLE_LATCH) else $error("latch not cleared");
   wip_start_a: assert property ($rose(WRITE_IN_PROGRESS) |->
      WRITE_ENABLE_LATCH && CHIP_SEL_N) else $error("write cycle without cause");
   wip_end_a: assert property ($fell(WRITE_IN_PROGRESS) |-> !WRITE_ENABLE_LATCH)
      else $error("latch kept after write cycle");
   wip_len_a: assert property ($fell(WRITE_IN_PROGRESS) |->
      busy_ff >= WC_CYCLES - 4 && busy_ff <= WC_CYCLES) else $error("write cycle length");
   nv_hold_a: assert property (!STATUS_LOAD && !$past(STATUS_LOAD) &&
      !$past(STATUS_LOAD, 2) |=> $stable(nv)) else $error("status bits moved");
   // ========
   // covers
   write_c: cover property ($rose(WRITE_IN_PROGRESS));
   read_c: cover property ($rose(SDO_OE));
   end_read_c: cover property ($fell(SDO_OE));
endmodule
bind sre_top sre_top_assertions #(.WC_CYCLES(WC_CYCLES)) u_chk (
   .CLOCK(CLOCK), .RESETN(RESETN), .CHIP_SEL_N(CHIP_SEL_N), .SCLK(SCLK), .SDO(SDO),
   .SDO_OE(SDO_OE), .WRITE_ENABLE_SET(WRITE_ENABLE_SET), .WRITE_ENABLE_CLR(WRITE_ENABLE_CLR),
   .STATUS_LOAD(STATUS_LOAD), .WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH),
   .WRITE_IN_PROGRESS(WRITE_IN_PROGRESS), .STATUS_WRITE_DISABLE(STATUS_WRITE_DISABLE),
   .BLOCK_PROTECT_HI(BLOCK_PROTECT_HI), .BLOCK_PROTECT_LO(BLOCK_PROTECT_LO));

// ===== tb/sre_top_tb.sv
// sre_top_tb: self-checking bench of the eeprom command core
// assumes sre_spi_master as bus host and a shortened write cycle
`timescale 1ns/10ps
`include "sre_map.svh"
module sre_top_tb;
   import sre_pkg::*;
   typedef struct {
      logic [15:0] wa;
      int          n;
      sre_byte_t   d;
      logic [15:0] ra;
      int          rn;
      sre_byte_t   ex [3];
   } sre_row_t;
   // long enough to issue commands during a cycle
   localparam int WC = 6000;
   logic      clk;
   logic      rstn;
   logic      cs_n;
   logic      sck;
   logic      mosi;
   logic      sdo;
   logic      sdo_oe;
   wire       miso;
   logic      we_set;
   logic      we_clr;
   logic      st_load;
   sre_nv_t   st_data;
   logic      write_enable_latch;
   logic      write_in_progress;
   sre_nv_t   nv;
   sre_byte_t shadow [32768];
   sre_byte_t r;
   sre_byte_t got [4];
   int        error_cnt;
   int        n_checks;
   int        k;
   // write address, count, first byte; read address, count, expected stream
   sre_row_t  rows [3] = '{'{16'h0010, 1, 8'h5a, 16'h000f, 3, '{8'hff, 8'h5a, 8'hff}},
                          '{16'h8020, 2, 8'h30, 16'h0020, 2, '{8'h30, 8'h31, 8'hff}},
                          '{16'h003e, 4, 8'hc0, 16'h0000, 3, '{8'hc2, 8'hc3, 8'hff}}};
   assign miso = sdo_oe ? sdo : 1'bz;
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   sre_spi_master host (.clk(clk), .cs_n(cs_n), .sck(sck), .mosi(mosi), .miso(miso));
   sre_top #(.WC_CYCLES(WC)) uut (
      .CLOCK(clk), .RESETN(rstn), .CHIP_SEL_N(cs_n), .SCLK(sck), .SDI(mosi), .SDO(sdo),
      .SDO_OE(sdo_oe), .WRITE_ENABLE_SET(we_set), .WRITE_ENABLE_CLR(we_clr),
      .STATUS_LOAD(st_load), .STATUS_DATA(st_data), .WRITE_ENABLE_LATCH(write_enable_latch),
      .WRITE_IN_PROGRESS(write_in_progress), .STATUS_WRITE_DISABLE(nv[2]), .BLOCK_PROTECT_HI(nv[1]),
      .BLOCK_PROTECT_LO(nv[0]));
   // ========
   // tasks
   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic pulse(ref logic s);
      @(negedge clk);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask
   task automatic wait_idle();
      k = 0;
      while (write_in_progress !== 1'b0 && k < 3 * WC) begin
         @(negedge clk);
         k++;
      end
      if (k >= 3 * WC) begin
         error_cnt++;
         stop_test();
      end
   endtask
   task automatic wr(input logic [15:0] a, input int n, input sre_byte_t d, input bit upd);
      logic [14:0] p;
      host.sel();
      host.xb(`SRE_OP_WRITE, r);
      host.xb(a[15:8], r);
      host.xb(a[7:0], r);
      for (int i = 0; i < n; i++) begin
         p = {a[14:6], 6'(a[5:0] + i)};
         host.xb(8'(d + i), r);
         if (upd) shadow[p] = 8'(d + i);
      end
      host.desel();
   endtask
   // refused read leaves the line floating
   task automatic rd(input logic [15:0] a, input int n, input bit refused);
      host.sel();
      host.xb(`SRE_OP_READ, r);
      host.xb(a[15:8], r);
      host.xb(a[7:0], r);
      for (int i = 0; i < n; i++) begin
         host.xb(8'h00, r);
         got[i] = r;
         check("read data", r, refused ? 8'hzz : shadow[15'(a + i)]);
      end
      host.desel();
   endtask
   // ========
   // main sequence
   initial begin
      rstn = 1'b0;
      we_set = 1'b0;
      we_clr = 1'b0;
      st_load = 1'b0;
      st_data = 3'h0;
      foreach (shadow[i]) shadow[i] = `SRE_ERASED;
      repeat (20) @(negedge clk);
      rstn = 1'b1;
      repeat (8) @(negedge clk);
      check("latch", write_enable_latch, 8'h00);
      check("busy", write_in_progress, 8'h00);
      check("drive", sdo_oe, 8'h00);
      check("status bits", nv, 8'h00);
      $display("test reset done");
      foreach (rows[i]) begin
         pulse(we_set);
         wr(rows[i].wa, rows[i].n, rows[i].d, 1'b1);
         check("busy after write", write_in_progress, 8'h01);
         wait_idle();
         check("latch after cycle", write_enable_latch, 8'h00);
         rd(rows[i].ra, rows[i].rn, 1'b0);
         for (int j = 0; j < rows[i].rn; j++) begin
            check("row data", got[j], rows[i].ex[j]);
         end
         $display("test row %0d done", i);
      end
      rd(16'h7fff, 2, 1'b0);
      wr(16'h0100, 1, 8'h11, 1'b0);
      check("busy without latch", write_in_progress, 8'h00);
      pulse(we_set);
      host.sel();
      host.xb(`SRE_OP_WRITE, r);
      host.xb(8'h01, r);
      host.xb(8'h02, r);
      repeat (4) host.bit1(1'b1, r[0]);
      host.desel();
      check("busy torn byte", write_in_progress, 8'h00);
      pulse(we_clr);
      check("latch cleared", write_enable_latch, 8'h00);
      $display("test refusals done");
      st_data = 3'h5;
      pulse(st_load);
      repeat (4) @(negedge clk);
      check("status load", nv, 8'h05);
      pulse(we_set);
      wr(16'h7fc0, 1, 8'h22, 1'b0);
      check("busy protected", write_in_progress, 8'h00);
      rstn = 1'b0;
      repeat (20) @(negedge clk);
      rstn = 1'b1;
      repeat (8) @(negedge clk);
      check("status kept", nv, 8'h05);
      check("latch reset", write_enable_latch, 8'h00);
      rd(16'h7fc0, 1, 1'b0);
      // top half, then whole array protected
      for (int j = 2; j < 4; j++) begin
         st_data = 3'(j);
         pulse(st_load);
         check("status load", nv, 8'(j));
         pulse(we_set);
         wr(j == 2 ? 16'h4000 : 16'h0100, 1, 8'h66, 1'b0);
         check("busy protected", write_in_progress, 8'h00);
      end
      st_data = 3'h0;
      pulse(st_load);
      $display("test protect done");
      pulse(we_set);
      wr(16'h0200, 1, 8'h44, 1'b1);
      pulse(we_set);
      wr(16'h0201, 1, 8'h55, 1'b0);
      rd(16'h0200, 1, 1'b1);
      wait_idle();
      rd(16'h0200, 2, 1'b0);
      host.sel();
      host.xb(`SRE_OP_READ, r);
      host.xb(8'h00, r);
      host.xb(8'h10, r);
      repeat (3) host.bit1(1'b0, r[0]);
      host.desel();
      check("drive after abort", sdo_oe, 8'h00);
      $display("test busy and abort done");
      stop_test();
   end
endmodule
